/* File: hdl/tcc_pkg.sv */
// Constants and types for the 16-bit timer control, capture and compare block.
package tcc_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h81;
  localparam logic [7:0] ADDR_CTRL_C = 8'h82;
  localparam logic [7:0] ADDR_CNT_L = 8'h84;
  localparam logic [7:0] ADDR_CNT_H = 8'h85;
  localparam logic [7:0] ADDR_CAP_L = 8'h86;
  localparam logic [7:0] ADDR_CAP_H = 8'h87;
  localparam logic [7:0] ADDR_CMPA_L = 8'h88;
  localparam logic [7:0] ADDR_CMPA_H = 8'h89;
  localparam logic [7:0] ADDR_CMPB_L = 8'h8a;
  localparam logic [7:0] ADDR_CMPB_H = 8'h8b;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h6f;
  localparam logic [7:0] ADDR_FLAGS = 8'h36;

  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int B_FILT_EN = 7;
  localparam int B_EDGE_SEL = 6;
  localparam int B_FORCE_A = 7;
  localparam int B_FORCE_B = 6;
  localparam int B_CAP = 5;
  localparam int B_CMPB = 2;
  localparam int B_CMPA = 1;
  localparam int B_OVF = 0;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'hdf;
  localparam logic [7:0] IRQ_MASK = 8'h27;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // ----------------------------------------
  // Clock select codes and prescaler taps
  // ----------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_BITS = 10;
  localparam int TAP8 = 3;
  localparam int TAP64 = 6;
  localparam int TAP256 = 8;
  localparam int TAP1024 = 10;
  localparam int FILT_LEN = 4;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_t;

endpackage

/* File: hdl/tcc_timer.sv */
// 16-bit timer with clock select, capture, compare, force strobes and interrupt flags.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module tcc_timer
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire tcc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic comparator_capture_sel,
  input wire logic ext_count_pin,
  input wire logic global_irq_en,
  input wire logic [3:0] vector_ack,
  output logic [3:0] irq_req,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic [3:0] waveform_mode,
  output logic [1:0] compare_output_mode_a,
  output logic [1:0] compare_output_mode_b
);

  // ----------------------------------------
  // Mode helpers
  // ----------------------------------------
  // Up/down counting modes.
  function automatic logic is_dual(input logic [3:0] m);
    return m inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11};
  endfunction
  // Single-slope PWM modes.
  function automatic logic is_fast(input logic [3:0] m);
    return m inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15};
  endfunction
  // Modes where the capture register is TOP.
  function automatic logic cap_is_top(input logic [3:0] m);
    return m inside {4'd8, 4'd10, 4'd12, 4'd14};
  endfunction
  // TOP value of the count sequence.
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                         input logic [15:0] ic);
    unique case (m)
      4'd1, 4'd5: return 16'h00ff;
      4'd2, 4'd6: return 16'h01ff;
      4'd3, 4'd7: return 16'h03ff;
      4'd4, 4'd9, 4'd11, 4'd15: return ca;
      4'd8, 4'd10, 4'd12, 4'd14: return ic;
      default: return CNT_MAX;
    endcase
  endfunction
  // Compare output action on a match or a forced match.
  function automatic logic wave_next(input logic cur, input logic [1:0] com);
    unique case (com)
      2'b01: return ~cur;
      2'b10: return 1'b0;
      2'b11: return 1'b1;
      default: return cur;
    endcase
  endfunction
  // High-byte address of any 16-bit register.
  function automatic logic is_hi(input logic [7:0] a);
    return a inside {ADDR_CNT_H, ADDR_CAP_H, ADDR_CMPA_H, ADDR_CMPB_H};
  endfunction

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] irq_en_q;
  logic [7:0] flags_q;
  logic [7:0] temp_q;
  logic [15:0] cnt_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  logic [15:0] cap_q;
  logic up_q;
  logic block_q;
  logic [PRE_BITS-1:0] pre_q;
  logic ext_q;
  logic [FILT_LEN-1:0] smp_q;
  logic filt_q;
  logic filt_prev_q;
  logic [7:0] rdata_q;
  logic [3:0] mode;
  logic [15:0] top;
  logic pwm;
  logic tick;
  logic at_top;
  logic cap_src;
  logic cap_evt;
  logic hit_a;
  logic hit_b;
  logic set_ovf;
  logic set_cap;
  logic force_a;
  logic force_b;
  logic wr_cnt;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  // Mode is assembled from both control registers.
  assign mode = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
  assign pwm = is_dual(mode) || is_fast(mode);
  assign top = top_of(mode, cmpa_q, cap_q);
  assign at_top = (cnt_q == top);
  assign wr_cnt = bus.wr && (bus.addr == ADDR_CNT_L);
  assign waveform_mode = mode;
  assign compare_output_mode_a = ctrl_a_q[7:6];
  assign compare_output_mode_b = ctrl_a_q[5:4];
  assign rdata = rdata_q;

  // Control and enable registers; reserved bits are dropped on write so they read zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_a_q <= RESET_BYTE;
      ctrl_b_q <= RESET_BYTE;
      irq_en_q <= RESET_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_CTRL_A) ctrl_a_q <= bus.wdata & CTRL_A_MASK;
      if (bus.addr == ADDR_CTRL_B) ctrl_b_q <= bus.wdata & CTRL_B_MASK;
      if (bus.addr == ADDR_IRQ_EN) irq_en_q <= bus.wdata & IRQ_MASK;
    end
  end

  // ----------------------------------------
  // Clock select and prescaler
  // ----------------------------------------
  // The prescaler runs freely, so a divided tick may come early after a code change.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      ext_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 1'b1;
      ext_q <= ext_count_pin; // Pin is read whatever its direction.
    end
  end

  // Timer tick per clock select code.
  always_comb begin
    unique case (ctrl_b_q[2:0])
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &pre_q[TAP8-1:0];
      CS_DIV64: tick = &pre_q[TAP64-1:0];
      CS_DIV256: tick = &pre_q[TAP256-1:0];
      CS_DIV1024: tick = &pre_q[TAP1024-1:0];
      CS_EXT_FALL: tick = ext_q && !ext_count_pin;
      CS_EXT_RISE: tick = !ext_q && ext_count_pin;
    endcase
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // A CPU write has priority over counting; it also arms the match block.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= RESET_WORD;
      up_q <= 1'b1;
    end else if (wr_cnt) begin
      cnt_q <= {temp_q, bus.wdata};
    end else if (tick) begin
      if (is_dual(mode)) begin
        if (up_q && at_top) begin
          up_q <= 1'b0;
          cnt_q <= cnt_q - 16'h0001;
        end else if (!up_q && cnt_q == RESET_WORD) begin
          up_q <= 1'b1;
          cnt_q <= cnt_q + 16'h0001;
        end else begin
          cnt_q <= up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        end
      end else if (mode != 4'd0 && mode != 4'd13 && at_top) begin
        cnt_q <= RESET_WORD; // Only a real match clears, never a force.
        up_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        up_q <= 1'b1;
      end
    end
  end

  // The block lasts until the first tick after the write has passed.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Compare, force and waveform outputs
  // ----------------------------------------
  assign hit_a = tick && !block_q && (cnt_q == cmpa_q);
  assign hit_b = tick && !block_q && (cnt_q == cmpb_q);
  assign force_a = bus.wr && bus.addr == ADDR_CTRL_C && bus.wdata[B_FORCE_A] && !pwm;
  assign force_b = bus.wr && bus.addr == ADDR_CTRL_C && bus.wdata[B_FORCE_B] && !pwm;

  // Compare registers update at once; there is no PWM buffering.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmpa_q <= RESET_WORD;
      cmpb_q <= RESET_WORD;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_CMPA_L) cmpa_q <= {temp_q, bus.wdata};
      if (bus.addr == ADDR_CMPB_L) cmpb_q <= {temp_q, bus.wdata};
    end
  end

  // Non-PWM outputs follow match or force; in PWM modes both outputs hold their value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else if (!pwm) begin
      if (hit_a || force_a) wave_out_a <= wave_next(wave_out_a, ctrl_a_q[7:6]);
      if (hit_b || force_b) wave_out_b <= wave_next(wave_out_b, ctrl_a_q[5:4]);
    end
  end

  // ----------------------------------------
  // Capture input path
  // ----------------------------------------
  assign cap_src = comparator_capture_sel ? comparator_out : capture_pin;

  // Filter needs four equal samples before it moves; this costs four cycles of delay.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      smp_q <= '0;
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
    end else begin
      smp_q <= {smp_q[FILT_LEN-2:0], cap_src};
      filt_prev_q <= filt_q;
      if (!ctrl_b_q[B_FILT_EN]) filt_q <= cap_src;
      else if (&smp_q) filt_q <= 1'b1;
      else if (~|smp_q) filt_q <= 1'b0;
    end
  end

  // Edge choice; capture is off while the capture register is TOP.
  assign cap_evt = !cap_is_top(mode) &&
                   (ctrl_b_q[B_EDGE_SEL] ? (filt_q && !filt_prev_q) : (!filt_q && filt_prev_q));

  // A capture beats a software write in the same cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_q <= RESET_WORD;
    end else if (cap_evt) begin
      cap_q <= cnt_q;
    end else if (bus.wr && bus.addr == ADDR_CAP_L) begin
      cap_q <= {temp_q, bus.wdata};
    end
  end

  // ----------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------
  // Overflow point per mode family.
  always_comb begin
    if (is_dual(mode)) set_ovf = tick && !up_q && cnt_q == RESET_WORD;
    else if (is_fast(mode)) set_ovf = tick && at_top;
    else set_ovf = tick && cnt_q == CNT_MAX;
  end

  // Capture flag source depends on whether the capture register is TOP.
  assign set_cap = cap_is_top(mode) ? (tick && up_q && at_top) : cap_evt;
  // Flags to set and to clear this cycle; a vector acknowledge clears like a written one.
  always_comb begin
    set_v = '0;
    set_v[B_CAP] = set_cap;
    set_v[B_CMPA] = hit_a; // Forces never reach here.
    set_v[B_CMPB] = hit_b;
    set_v[B_OVF] = set_ovf;
    clr_v = (bus.wr && bus.addr == ADDR_FLAGS) ? bus.wdata : '0;
    clr_v[B_CAP] = clr_v[B_CAP] | vector_ack[3];
    clr_v[B_CMPB] = clr_v[B_CMPB] | vector_ack[2];
    clr_v[B_CMPA] = clr_v[B_CMPA] | vector_ack[1];
    clr_v[B_OVF] = clr_v[B_OVF] | vector_ack[0];
  end

  // A new event in the clearing cycle survives because set is applied last.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_q <= RESET_BYTE;
    end else begin
      flags_q <= ((flags_q & ~clr_v) | set_v) & IRQ_MASK;
    end
  end

  // Request needs enable, global flag and pending flag together.
  assign irq_req = {4{global_irq_en}} &
                   {flags_q[B_CAP] & irq_en_q[B_CAP], flags_q[B_CMPB] & irq_en_q[B_CMPB],
                    flags_q[B_CMPA] & irq_en_q[B_CMPA], flags_q[B_OVF] & irq_en_q[B_OVF]};

  // ----------------------------------------
  // Shared high-byte latch and read path
  // ----------------------------------------
  // High writes park in the latch; low reads load it with the matching high byte.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      temp_q <= RESET_BYTE;
    end else if (bus.wr && is_hi(bus.addr)) begin
      temp_q <= bus.wdata;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CNT_L: temp_q <= cnt_q[15:8];
        ADDR_CAP_L: temp_q <= cap_q[15:8];
        ADDR_CMPA_L: temp_q <= cmpa_q[15:8];
        ADDR_CMPB_L: temp_q <= cmpb_q[15:8];
        default: temp_q <= temp_q;
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped addresses and force bits read zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= RESET_BYTE;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CTRL_A: rdata_q <= ctrl_a_q;
        ADDR_CTRL_B: rdata_q <= ctrl_b_q;
        ADDR_CNT_L: rdata_q <= cnt_q[7:0];
        ADDR_CAP_L: rdata_q <= cap_q[7:0];
        ADDR_CMPA_L: rdata_q <= cmpa_q[7:0];
        ADDR_CMPB_L: rdata_q <= cmpb_q[7:0];
        ADDR_IRQ_EN: rdata_q <= irq_en_q;
        ADDR_FLAGS: rdata_q <= flags_q;
        default: rdata_q <= is_hi(bus.addr) ? temp_q : RESET_BYTE;
      endcase
    end else begin
      rdata_q <= RESET_BYTE;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_cnt_wr;
    wr_cnt;
  endsequence
  sequence s_blocked_tick;
    !wr_cnt && tick;
  endsequence
  filt_hold_a: assert property (ctrl_b_q[B_FILT_EN] && $changed(filt_q) |->
    $past(smp_q) == {FILT_LEN{filt_q}}) else $error("filter moved early");
  cap_copy_a: assert property (cap_evt |=> cap_q == $past(cnt_q) && flags_q[B_CAP])
    else $error("capture lost");
  cap_off_a: assert property (cap_is_top(mode) |-> !cap_evt) else $error("capture while top");
  clk_stop_a: assert property (ctrl_b_q[2:0] == CS_STOP && !wr_cnt |=> $stable(cnt_q))
    else $error("stopped counter moved");
  ext_rise_a: assert property (ctrl_b_q[2:0] == CS_EXT_RISE && $rose(ext_count_pin) |-> tick)
    else $error("missed pin edge");
  force_rd_a: assert property (bus.rd && bus.addr == ADDR_CTRL_C |=> rdata == RESET_BYTE)
    else $error("force bits read back");
  match_blk_a: assert property (s_cnt_wr ##1 s_blocked_tick |-> !hit_a && !hit_b)
    else $error("match after counter write");
  irq_gate_a: assert property (!global_irq_en |-> irq_req == 4'h0) else $error("ungated irq");
  cmp_flag_a: assert property (hit_a |=> flags_q[B_CMPA]) else $error("compare flag missing");
  flag_clr_a: assert property (bus.wr && bus.addr == ADDR_FLAGS && bus.wdata[B_OVF] &&
    !set_ovf |=> !flags_q[B_OVF]) else $error("flag not cleared");

endmodule

`default_nettype wire

/* File: testbench/tcc_timer_bench.sv */
// Self-checking register-level bench for the 16-bit timer control, capture and compare block.
`timescale 1ns/1ns
`default_nettype none

module tcc_timer_bench;
  import tcc_pkg::*;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  tcc_bus_t bus = '0;
  logic [7:0] rdata;
  logic capture_pin = 1'b1;
  logic comparator_out = 1'b0;
  logic comparator_capture_sel = 1'b0;
  logic ext_count_pin = 1'b0;
  logic global_irq_en = 1'b0;
  logic [3:0] vector_ack = 4'h0;
  logic [3:0] irq_req;
  logic wave_out_a;
  logic wave_out_b;
  logic [3:0] waveform_mode;
  logic [1:0] compare_output_mode_a;
  logic [1:0] compare_output_mode_b;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] rv;
  logic [15:0] wv;
  logic was_a;
  logic was_b;
  int divs [5] = '{1, 8, 64, 256, 1024};

  // ----------------------------------------
  // Clock, device and watchdog
  // ----------------------------------------
  // A 25 MHz clock; every rule time below is counted in these cycles.
  always #20 core_clk = ~core_clk;

  tcc_timer dut (
    .core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .comparator_capture_sel(comparator_capture_sel),
    .ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en), .vector_ack(vector_ack),
    .irq_req(irq_req), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .waveform_mode(waveform_mode), .compare_output_mode_a(compare_output_mode_a),
    .compare_output_mode_b(compare_output_mode_b)
  );

  // The tests need about 11500 cycles, so a hang is cut off well beyond that.
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus <= '{a, d, 1'b0, 1'b0};
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // High byte goes first so the shared latch is loaded before the low byte commits.
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask

  // Low byte goes first so the latch holds the matching high byte.
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_count_pin <= 1'b1;
      idle(4);
      ext_count_pin <= 1'b0;
      idle(4);
    end
  endtask

  task automatic pin(input logic v, input int n);
    @(posedge core_clk);
    capture_pin <= v;
    idle(n);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    idle(16);
    @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, the writable bits of control register B and an unmapped place.
    rdchk(ADDR_CTRL_A, 8'h00);
    rdchk(ADDR_CTRL_B, 8'h00);
    rdchk(ADDR_IRQ_EN, 8'h00);
    rdchk(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL_B, 8'hdf);
    rdchk(ADDR_CTRL_B, 8'hdf);
    wr(ADDR_CTRL_B, 8'h00);
    rdchk(8'h90, 8'h00);
    // Shared high-byte latch: a high read returns what the last low read loaded.
    wr16(ADDR_CNT_L, 16'h1234);
    wr16(ADDR_CMPA_L, 16'habcd);
    rdchk(ADDR_CNT_L, 8'h34);
    rdchk(ADDR_CMPA_H, 8'h12);
    rd16(ADDR_CMPA_L, wv);
    chk(wv, 16'habcd);
    // Stopped clock holds the count.
    idle(50);
    rd16(ADDR_CNT_L, wv);
    chk(wv, 16'h1234);
    // Each prescaler tap runs for eight of its periods; start and stop slack is allowed.
    for (int i = 0; i < 5; i++) begin
      wr16(ADDR_CNT_L, 16'h0000);
      wr(ADDR_CTRL_B, 8'(i + 1));
      idle(8 * divs[i]);
      wr(ADDR_CTRL_B, 8'h00);
      rd16(ADDR_CNT_L, wv);
      compares++;
      if ($isunknown(wv) || wv < 16'h0007 || wv > 16'h000b) begin
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, wv, 16'h0008);
      end
    end
    // External pin, falling then rising edges, driven as plain pulses.
    wr16(ADDR_CNT_L, 16'h0000);
    wr(ADDR_CTRL_B, 8'h06);
    pulses(5);
    wr(ADDR_CTRL_B, 8'h00);
    rd16(ADDR_CNT_L, wv);
    chk(wv, 16'h0005);
    wr16(ADDR_CNT_L, 16'h0000);
    wr(ADDR_CTRL_B, 8'h07);
    pulses(3);
    wr(ADDR_CTRL_B, 8'h00);
    rd16(ADDR_CNT_L, wv);
    chk(wv, 16'h0003);
    // Compare flags, interrupt gating and both ways of clearing.
    wr16(ADDR_CMPA_L, 16'h0010);
    wr16(ADDR_CMPB_L, 16'h0020);
    wr16(ADDR_CNT_L, 16'h0000);
    wr(ADDR_FLAGS, 8'h27);
    wr(ADDR_CTRL_B, 8'h01);
    idle(64);
    wr(ADDR_CTRL_B, 8'h00);
    rdchk(ADDR_FLAGS, 8'h06);
    wr(ADDR_IRQ_EN, 8'hff);
    rdchk(ADDR_IRQ_EN, 8'h27);
    #1 chk({12'h000, irq_req}, 16'h0000);
    @(posedge core_clk);
    global_irq_en <= 1'b1;
    @(posedge core_clk);
    #1 chk({12'h000, irq_req}, 16'h0006);
    @(posedge core_clk);
    vector_ack <= 4'h2;
    @(posedge core_clk);
    vector_ack <= 4'h0;
    rdchk(ADDR_FLAGS, 8'h04);
    wr(ADDR_FLAGS, 8'h00);
    rdchk(ADDR_FLAGS, 8'h04);
    wr(ADDR_FLAGS, 8'h04);
    rdchk(ADDR_FLAGS, 8'h00);
    // A counter write that lands on the compare value must not match next tick.
    wr16(ADDR_CNT_L, 16'h0100);
    wr(ADDR_CTRL_B, 8'h01);
    wr16(ADDR_CNT_L, 16'h0010);
    wr(ADDR_CTRL_B, 8'h00);
    rdchk(ADDR_FLAGS, 8'h00);
    // Overflow in normal mode.
    wr16(ADDR_CNT_L, 16'hfffe);
    wr(ADDR_CTRL_B, 8'h01);
    idle(8);
    wr(ADDR_CTRL_B, 8'h00);
    rdchk(ADDR_FLAGS, 8'h01);
    wr(ADDR_FLAGS, 8'h27);
    // Capture on falling edge, none on rising edge, then the other way round.
    wr16(ADDR_CNT_L, 16'h0abc);
    pin(1'b0, 8);
    rdchk(ADDR_FLAGS, 8'h20);
    rd16(ADDR_CAP_L, wv);
    chk(wv, 16'h0abc);
    wr(ADDR_FLAGS, 8'h20);
    pin(1'b1, 8);
    rdchk(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL_B, 8'h40);
    wr16(ADDR_CNT_L, 16'h0def);
    pin(1'b0, 8);
    rdchk(ADDR_FLAGS, 8'h00);
    pin(1'b1, 8);
    rdchk(ADDR_FLAGS, 8'h20);
    rd16(ADDR_CAP_L, wv);
    chk(wv, 16'h0def);
    // Filter: a three-cycle glitch is ignored, a steady level gets through.
    wr(ADDR_CTRL_B, 8'hc0);
    pin(1'b0, 10);
    wr(ADDR_FLAGS, 8'h20);
    pin(1'b1, 2);
    pin(1'b0, 10);
    rdchk(ADDR_FLAGS, 8'h00);
    pin(1'b1, 10);
    rdchk(ADDR_FLAGS, 8'h20);
    // Comparator as capture source.
    wr(ADDR_CTRL_B, 8'h40);
    wr(ADDR_FLAGS, 8'h20);
    @(posedge core_clk);
    comparator_capture_sel <= 1'b1;
    idle(4);
    comparator_out <= 1'b1;
    idle(8);
    rdchk(ADDR_FLAGS, 8'h20);
    comparator_capture_sel <= 1'b0;
    // Capture register as TOP: the pin no longer captures.
    wr16(ADDR_CNT_L, 16'h0100);
    wr(ADDR_CTRL_B, 8'h58);
    #1 chk({12'h000, waveform_mode}, 16'h000c);
    wr(ADDR_FLAGS, 8'h20);
    pin(1'b0, 8);
    pin(1'b1, 8);
    rdchk(ADDR_FLAGS, 8'h00);
    rd16(ADDR_CAP_L, wv);
    chk(wv, 16'h0def);
    // With the capture register as TOP the capture flag marks TOP instead of a pin edge.
    wr16(ADDR_CAP_L, 16'h0018);
    wr16(ADDR_CNT_L, 16'h0000);
    wr(ADDR_CTRL_B, 8'h59);
    idle(40);
    wr(ADDR_CTRL_B, 8'h00);
    rdchk(ADDR_FLAGS, 8'h22);
    wr(ADDR_FLAGS, 8'h27);
    // Forced compare toggles the outputs in normal mode without flags; ignored in PWM.
    wr(ADDR_CTRL_A, 8'h50);
    was_a = wave_out_a;
    was_b = wave_out_b;
    wr(ADDR_CTRL_C, 8'hc0);
    idle(2);
    chk({15'h0000, wave_out_a}, {15'h0000, ~was_a});
    chk({15'h0000, wave_out_b}, {15'h0000, ~was_b});
    chk({14'h0000, compare_output_mode_b}, 16'h0001);
    rdchk(ADDR_FLAGS, 8'h00);
    rdchk(ADDR_CTRL_C, 8'h00);
    wr(ADDR_CTRL_B, 8'h10);
    wr(ADDR_CTRL_A, 8'h41);
    #1 chk({12'h000, waveform_mode}, 16'h0009);
    chk({14'h0000, compare_output_mode_a}, 16'h0001);
    was_a = wave_out_a;
    wr(ADDR_CTRL_C, 8'h80);
    idle(2);
    chk({15'h0000, wave_out_a}, {15'h0000, was_a});
    wrap_up();
  end
endmodule

`default_nettype wire
